// ===== common/leb_pkg.sv
package leb_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [3:0]  ADDR_CTRL       = 4'h0;  // blanking control word
  localparam logic [3:0]  ADDR_PERIOD     = 4'h4;  // blanking length in cycles
  localparam logic [3:0]  ADDR_STATUS     = 4'h8;  // live state, read only
  // ---------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------
  localparam int          BIT_HI_RISE     = 15;
  localparam int          BIT_HI_FALL     = 14;
  localparam int          BIT_LO_RISE     = 13;
  localparam int          BIT_LO_FALL     = 12;
  localparam int          BIT_FLT_EN      = 11;
  localparam int          BIT_CL_EN       = 10;
  localparam int          BIT_SEL_HIGH    = 5;
  localparam int          BIT_SEL_LOW     = 4;
  localparam int          BIT_HI_OUT_H    = 3;
  localparam int          BIT_HI_OUT_L    = 2;
  localparam int          BIT_LO_OUT_H    = 1;
  localparam int          BIT_LO_OUT_L    = 0;
  // writable bits: 15..10 and 5..0, bits 9..6 read zero
  localparam logic [15:0] CTRL_WMASK      = 16'hfc3f;
  localparam logic [15:0] CTRL_RESET      = 16'h0000;
  localparam logic [15:0] PERIOD_RESET    = 16'h0000;
  // ---------------------------------------------------------------
  // counter states
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_BLANK = 1'b1
  } blank_state_t;
endpackage

// ===== hw/leb_edge_detect.sv
`timescale 1ns/1ps
// two-flop synchroniser followed by an edge detector
module leb_edge_detect (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic meta;   // first stage, read only by sync
  logic sync;   // second stage
  logic last;   // previous synchronised level

  // ---------------------------------------------------------------
  // sampling chain
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= pin_i;
      sync <= meta;
      last <= sync;
    end
  end

  assign level_o = sync;
  assign rise_o  = sync & ~last;
  assign fall_o  = ~sync & last;
endmodule

// ===== hw/pwm_leading_edge_blanking_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// R1: high-side rising edge restarts blanking when enabled
// R2: high-side falling edge restarts blanking when enabled
// R3: low-side rising edge starts blanking when enabled
// R4: low-side falling edge starts blanking when enabled
// R5: fault input masked during blanking when enabled
// R6: current-limit input masked during blanking when enabled
// R7: blank both inputs while select signal high
// R8: control bits nine to six read zero
// R9: control bits read/write, cleared at reset
// R10: blank both inputs while select signal low
// R11: blank both inputs while high-side output high
// R12: blanking lasts while counter runs after trigger
module pwm_leading_edge_blanking_ctrl (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // pwm outputs and comparator inputs (asynchronous pins)
  input  wire logic        pwm_high_side_out_i,
  input  wire logic        pwm_low_side_out_i,
  input  wire logic        blank_sel_sig_i,
  input  wire logic        fault_in_i,
  input  wire logic        curlim_in_i,
  // qualified outputs toward the fault logic
  output logic             fault_o,
  output logic             curlim_o,
  output logic             blanking_o
);
  // ---------------------------------------------------------------
  // registers and wires
  // ---------------------------------------------------------------
  logic [15:0]             ctrl;          // blanking control word
  logic [15:0]             period;        // blanking length
  logic [15:0]             cnt;           // blanking counter
  leb_pkg::blank_state_t   state;         // counter state
  logic                    hi_lvl, hi_rise, hi_fall;
  logic                    lo_lvl, lo_rise, lo_fall;
  logic                    sel_lvl, flt_lvl, cl_lvl;
  logic                    flt_m, cl_m;   // first sync stages
  logic                    ack;           // registered acknowledge
  logic [31:0]             rdata;         // registered read data
  logic                    fault_q, curlim_q;

  // ---------------------------------------------------------------
  // pin synchronisers and edge detectors
  // ---------------------------------------------------------------
  leb_edge_detect u_hi (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (pwm_high_side_out_i),
    .level_o (hi_lvl),
    .rise_o  (hi_rise),
    .fall_o  (hi_fall)
  );
  leb_edge_detect u_lo (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (pwm_low_side_out_i),
    .level_o (lo_lvl),
    .rise_o  (lo_rise),
    .fall_o  (lo_fall)
  );
  leb_edge_detect u_sel (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (blank_sel_sig_i),
    .level_o (sel_lvl),
    .rise_o  (),
    .fall_o  ()
  );

  // fault and current-limit: plain two-flop synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flt_m  <= 1'b0;
      flt_lvl <= 1'b0;
      cl_m   <= 1'b0;
      cl_lvl <= 1'b0;
    end else begin
      flt_m  <= fault_in_i;
      flt_lvl <= flt_m;
      cl_m   <= curlim_in_i;
      cl_lvl <= cl_m;
    end
  end

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire         req      = cyc_i & stb_i & ~ack;
  wire         wr       = req & we_i;
  wire         hit_ctrl = (adr_i == leb_pkg::ADDR_CTRL);
  wire         hit_per  = (adr_i == leb_pkg::ADDR_PERIOD);
  wire         hit_stat = (adr_i == leb_pkg::ADDR_STATUS);
  // byte-lane merge for 16-bit registers
  wire  [15:0] lane_mask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
  wire  [15:0] next_ctrl = ((ctrl & ~lane_mask) | (dat_i[15:0] & lane_mask))
                           & leb_pkg::CTRL_WMASK;                 // [R8]
  wire  [15:0] next_period = (period & ~lane_mask) | (dat_i[15:0] & lane_mask);
  wire  [15:0] status_word = {11'h000, flt_lvl, cl_lvl, lo_lvl, hi_lvl,
                              (state == leb_pkg::ST_BLANK)};
  wire  [31:0] next_rdata = hit_ctrl ? {16'h0000, ctrl & leb_pkg::CTRL_WMASK}
                          : hit_per  ? {16'h0000, period}
                          : hit_stat ? {16'h0000, status_word}
                          : 32'h0000_0000;                        // unmapped reads zero

  // ---------------------------------------------------------------
  // register file, single-wait-state ack
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl   <= leb_pkg::CTRL_RESET;                              // [R9]
      period <= leb_pkg::PERIOD_RESET;
      ack    <= 1'b0;
      rdata  <= 32'h0000_0000;
    end else begin
      ack   <= req;
      rdata <= next_rdata;
      if (wr && hit_ctrl) begin
        ctrl <= next_ctrl;                                        // [R9]
      end
      if (wr && hit_per) begin
        period <= next_period;
      end
    end
  end

  assign ack_o = ack;
  assign dat_o = rdata;

  // ---------------------------------------------------------------
  // trigger and counter
  // ---------------------------------------------------------------
  wire trig = (ctrl[leb_pkg::BIT_HI_RISE] & hi_rise)              // [R1]
            | (ctrl[leb_pkg::BIT_HI_FALL] & hi_fall)              // [R2]
            | (ctrl[leb_pkg::BIT_LO_RISE] & lo_rise)              // [R3]
            | (ctrl[leb_pkg::BIT_LO_FALL] & lo_fall);             // [R4]
  wire cnt_done = (cnt <= 16'h0001);

  // counter restarts on every enabled edge, runs down to zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= leb_pkg::ST_IDLE;
      cnt   <= 16'h0000;
    end else begin
      case (state)
        leb_pkg::ST_IDLE: begin
          if (trig && period != 16'h0000) begin
            state <= leb_pkg::ST_BLANK;                           // [R12]
            cnt   <= period;
          end
        end
        leb_pkg::ST_BLANK: begin
          if (trig) begin
            cnt <= period;                                        // [R1] [R2]
            if (period == 16'h0000) begin
              state <= leb_pkg::ST_IDLE;
            end
          end else if (cnt_done) begin
            state <= leb_pkg::ST_IDLE;                            // [R12]
            cnt   <= 16'h0000;
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        default: begin
          state <= leb_pkg::ST_IDLE;
          cnt   <= 16'h0000;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // masking
  // ---------------------------------------------------------------
  wire leb_active = (state == leb_pkg::ST_BLANK);
  wire lvl_blank  = (ctrl[leb_pkg::BIT_SEL_HIGH] & sel_lvl)       // [R7]
                  | (ctrl[leb_pkg::BIT_SEL_LOW] & ~sel_lvl)       // [R10]
                  | (ctrl[leb_pkg::BIT_HI_OUT_H] & hi_lvl)        // [R11]
                  | (ctrl[leb_pkg::BIT_HI_OUT_L] & ~hi_lvl)
                  | (ctrl[leb_pkg::BIT_LO_OUT_H] & lo_lvl)
                  | (ctrl[leb_pkg::BIT_LO_OUT_L] & ~lo_lvl);
  wire flt_mask = (leb_active & ctrl[leb_pkg::BIT_FLT_EN]) | lvl_blank;  // [R5]
  wire cl_mask  = (leb_active & ctrl[leb_pkg::BIT_CL_EN]) | lvl_blank;   // [R6]

  // registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_q  <= 1'b0;
      curlim_q <= 1'b0;
    end else begin
      fault_q  <= flt_lvl & ~flt_mask;                            // [R5]
      curlim_q <= cl_lvl & ~cl_mask;                              // [R6]
    end
  end

  assign fault_o    = fault_q;
  assign curlim_o   = curlim_q;
  assign blanking_o = leb_active;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_hi_rise_start: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    (ctrl[leb_pkg::BIT_HI_RISE] && hi_rise && period > 16'h0001) |=> leb_active && cnt == $past(period))
    else $error("high rise did not start blanking");
  a_hi_fall_start: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    (ctrl[leb_pkg::BIT_HI_FALL] && hi_fall && period > 16'h0001) |=> leb_active)
    else $error("high fall did not start blanking");
  a_lo_rise_start: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    (ctrl[leb_pkg::BIT_LO_RISE] && lo_rise && period > 16'h0001) |=> leb_active)
    else $error("low rise did not start blanking");
  a_lo_fall_start: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    (ctrl[leb_pkg::BIT_LO_FALL] && lo_fall && period > 16'h0001) |=> leb_active)
    else $error("low fall did not start blanking");
  a_no_trig_idle: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
    (!leb_active && !trig) |=> !leb_active)
    else $error("blanking began without trigger");
  a_fault_masked: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    (leb_active && ctrl[leb_pkg::BIT_FLT_EN]) |=> !fault_q)
    else $error("fault passed during blanking");
  a_curlim_masked: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    (leb_active && ctrl[leb_pkg::BIT_CL_EN]) |=> !curlim_q)
    else $error("current limit passed during blanking");
  a_fault_pass: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    (!flt_mask && flt_lvl) |=> fault_q)
    else $error("unmasked fault lost");
  a_sel_high: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
    (ctrl[leb_pkg::BIT_SEL_HIGH] && sel_lvl) |=> !fault_q && !curlim_q)
    else $error("select high did not blank");
  a_sel_low: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    (ctrl[leb_pkg::BIT_SEL_LOW] && !sel_lvl) |=> !fault_q && !curlim_q)
    else $error("select low did not blank");
  a_hi_out_high: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    (ctrl[leb_pkg::BIT_HI_OUT_H] && hi_lvl) |=> !fault_q && !curlim_q)
    else $error("high output level did not blank");
  a_unimpl_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
    (ack && $past(hit_ctrl) && !$past(we_i)) |-> dat_o[9:6] == 4'h0)
    else $error("unimplemented bits read nonzero");
  a_ctrl_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
    (wr && hit_ctrl && sel_i[1:0] == 2'b11) |=> ctrl == ($past(dat_i[15:0]) & leb_pkg::CTRL_WMASK))
    else $error("control write not stored");
endmodule

// ===== test/leb_far_side.sv
`timescale 1ns/1ps
// ----------------------------------------
// far side: pwm stage and comparators
// ----------------------------------------
module leb_far_side (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [4:0] req_i,   // wanted levels: cl, flt, sel, lo, hi
  input  wire logic       slow_i,  // answer one cycle later
  output logic            hi_o,
  output logic            lo_o,
  output logic            sel_o,
  output logic            flt_o,
  output logic            cl_o
);
  logic [4:0] req_d;  // delayed copy for slow answers
  // pins change only just after a clock edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_d <= 5'h00;
      {cl_o, flt_o, sel_o, lo_o, hi_o} <= 5'h00;
    end else begin
      req_d <= req_i;
      {cl_o, flt_o, sel_o, lo_o, hi_o} <= slow_i ? req_d : req_i;
    end
  end
endmodule

// ===== test/pwm_leading_edge_blanking_ctrl_bench.sv
`timescale 1ns/1ps
module pwm_leading_edge_blanking_ctrl_bench;
  // ----------------------------------------
  // signals and model state
  // ----------------------------------------
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, slow = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0, q, r, dat_o;
  logic [4:0]  req = 5'h00;  // cl, flt, sel, lo, hi
  logic [3:0]  lanes = 4'hf; // byte lanes offered with each bus request
  logic        hi, lo, sel, flt, cl, fault_o, curlim_o, blanking_o, ack_o, m, re, fe;
  int          fail_count = 0, cmp_count = 0, seed = 4;
  int          nb, nf, nc, p, e, g;
  int          exp_q[$];  // expected read-back values
  logic [15:0] ec [7] = '{16'h8800, 16'h4400, 16'h2800, 16'h1400, 16'h0c00, 16'hcc00, 16'h3c00};
  int          ep [7] = '{0, 0, 1, 1, 0, 0, 1};  // pin: 0 high side, 1 low side

  always #2.5 clk_i = ~clk_i;

  leb_far_side u_far (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .slow_i(slow),
    .hi_o(hi), .lo_o(lo), .sel_o(sel), .flt_o(flt), .cl_o(cl));

  pwm_leading_edge_blanking_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(lanes), .dat_i(wdat), .dat_o(dat_o),
    .ack_o(ack_o), .pwm_high_side_out_i(hi), .pwm_low_side_out_i(lo),
    .blank_sel_sig_i(sel), .fault_in_i(flt), .curlim_in_i(cl), .fault_o(fault_o),
    .curlim_o(curlim_o), .blanking_o(blanking_o));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_of_test();
    $display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one classic wishbone cycle, read data lands in q
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    n = 0;
    // ack is sampled at rising edges only; data is taken at the same edge
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      end_of_test();
    end
    q = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  // count blanking and masked-output cycles
  task automatic step(input int n);
    repeat (n) begin
      @(negedge clk_i);
      nb += (blanking_o === 1'b1);
      nf += (fault_o === 1'b0);
      nc += (curlim_o === 1'b0);
    end
  endtask

  initial begin
    #250000;
    fail_count++;
    end_of_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    p = 5 + ($random(seed) & 7);
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, unmapped place included
    for (int a = 0; a < 16; a += 4) begin
      wb(1'b0, a[3:0], 32'h0);
      chk(q, 32'h0);
    end
    repeat (4) begin
      r = $random(seed);
      wb(1'b1, 4'h0, r);
      exp_q.push_back(r & 32'hfc3f);
      wb(1'b0, 4'h0, 32'h0);
      chk(q, exp_q.pop_front());
    end
    wb(1'b1, 4'hc, 32'hffffffff);
    wb(1'b0, 4'hc, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, 4'h4, p);
    wb(1'b0, 4'h4, 32'h0);
    chk(q, p);
    $display("test registers done");
    // trigger edges, masking, restart
    for (int i = 0; i < 7; i++) begin
      g = (i == 5) ? 3 : 30;
      wb(1'b1, 4'h0, ec[i]);
      @(posedge clk_i);
      req <= 5'h18;
      step(10);
      nb = 0; nf = 0; nc = 0;
      @(posedge clk_i);
      req[ep[i]] <= 1'b1;
      step(g);
      @(posedge clk_i);
      req[ep[i]] <= 1'b0;
      step(30);
      re = ep[i] ? ec[i][13] : ec[i][15];
      fe = ep[i] ? ec[i][12] : ec[i][14];
      e = (re && fe && g < p) ? g + p : (re + fe) * p;
      chk(nb, e);
      chk(nf, ec[i][11] ? e : 0);
      chk(nc, ec[i][10] ? e : 0);
    end
    $display("test edges done");
    // byte-lane write: only the upper lane of the period may change
    @(posedge clk_i);
    lanes <= 4'h2;
    wb(1'b1, 4'h4, 32'h0000_a5a5);
    lanes <= 4'hf;
    wb(1'b0, 4'h4, 32'h0);
    chk(q, 32'h0000_a500 | p);
    $display("test lanes done");
    // level blanking with random pins and prompt or slow far side
    repeat (12) begin
      r = $random(seed);
      wb(1'b1, 4'h0, r & 32'h3f);
      @(posedge clk_i);
      req <= r[10:6];
      slow <= r[11];
      step(10);
      m = (r[5] & r[8]) | (r[4] & ~r[8]) | (r[3] & r[6]) | (r[2] & ~r[6])
        | (r[1] & r[7]) | (r[0] & ~r[7]);
      chk({fault_o, curlim_o, blanking_o}, {r[9] & ~m, r[10] & ~m, 1'b0});
      wb(1'b0, 4'h8, 32'h0);
      chk(q, {r[9], r[10], r[7], r[6], 1'b0});
    end
    $display("test levels done");
    // second reset in mid-run
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 4'h0, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, 4'h4, 32'h0);
    chk(q, 32'h0);
    $display("test second reset done");
    end_of_test();
  end
endmodule
